// [common/cfg_ident_pkg.sv]
`default_nettype none
package cfg_ident_pkg;

	// configuration header dword indices (byte offset / 4)
	localparam logic [5:0] IDX_IDENT   = 6'h00;
	localparam logic [5:0] IDX_CMDSTAT = 6'h01;
	localparam logic [5:0] IDX_CLASS   = 6'h02;
	localparam logic [5:0] IDX_MISC    = 6'h03;

	// byte offsets of the halfword registers inside the header
	localparam logic [7:0] OFS_MAKER_ID  = 8'h00;
	localparam logic [7:0] OFS_DEVICE_TYPE_IDENTIFIER = 8'h02;
	localparam logic [7:0] OFS_COMMAND   = 8'h04;

	// command register field positions
	localparam int CMD_IO     = 0;
	localparam int CMD_MEM    = 1;
	localparam int CMD_MASTER = 2;
	localparam int CMD_SPEC   = 3;
	localparam int CMD_MWI    = 4;
	localparam int CMD_VGA    = 5;
	localparam int CMD_PERR   = 6;
	localparam int CMD_STEP   = 7;
	localparam int CMD_SERR   = 8;
	localparam int CMD_FBB    = 9;

	// writable command bits and their reset value
	localparam logic [15:0] CMD_WMASK = 16'h0156;
	localparam logic [15:0] CMD_RESET = 16'h0016;

	// misc dword byte lanes
	localparam int LANE_CACHE   = 0;
	localparam int LANE_LATENCY = 1;
	localparam logic [7:0] CACHE_RESET   = 8'h00;
	localparam logic [7:0] LATENCY_RESET = 8'h00;

	// physical-layer page select codes and register addresses
	localparam logic [2:0] PAGE_PORT   = 3'h0;
	localparam logic [2:0] PAGE_VENDOR = 3'h1;
	localparam logic [3:0] PA_COMPLY   = 4'h8;
	localparam logic [3:0] PA_COMPANY0 = 4'h9;
	localparam logic [3:0] PA_COMPANY1 = 4'hA;
	localparam logic [3:0] PA_COMPANY2 = 4'hB;
	localparam logic [3:0] PA_PRODUCT0 = 4'hC;
	localparam logic [3:0] PA_PRODUCT1 = 4'hD;
	localparam logic [3:0] PA_PRODUCT2 = 4'hE;
	localparam logic [7:0] COMPLY_RESET = 8'h01;

	// configuration access request from the host bridge decode
	typedef struct packed {
		logic        sel;
		logic        write;
		logic [5:0]  idx;
		logic [3:0]  be;
		logic [31:0] wdata;
	} cfg_req_t;

	// physical-layer register read request
	typedef struct packed {
		logic       rd;
		logic [2:0] page;
		logic [3:0] addr;
	} phy_req_t;

	// decoded command controls
	typedef struct packed {
		logic memEn;
		logic masterEn;
		logic mwiEn;
		logic perrEn;
		logic serrEn;
	} cmd_ctl_t;

endpackage : cfg_ident_pkg
`default_nettype wire

// [logic/pci_config_ident_command.sv]
// Notes on behaviour
// - command bit 0 reads zero; input/output space accesses are never claimed.
// - command bit 1 writable, resets one, gates response to memory cycles.
// - command bit 2 writable, resets one; zero blocks all bus mastering.
// - command bit 3 reads zero; special cycles are never monitored.
// - command bit 4 writable, resets one; allows write-and-invalidate when set.
// - command bit 5 reads zero; palette snooping stays disabled.
// - command bit 6 writable, resets zero; enables reaction to parity errors.
// - command bit 7 reads zero; no address or data stepping.
// - command bit 8 writable, resets zero; enables system error checking.
// - command bit 9 reads zero; back-to-back only to same target.
// - command bits 15 to 10 always read zero.
// - offset zero returns fixed read-only 16-bit maker identifier.
// - offset two returns fixed read-only 16-bit device type identifier.
// - vendor page exposes read-only 24-bit company code.
// - vendor page compliance level resets to one; unused locations read zero.
// - with card select low, present the header layout in dwords zero to three.
// - page select 001 picks vendor page; 000 picks port status page.
`default_nettype none
module pci_config_ident_command #(
	parameter logic [15:0] MAKER_ID     = 16'h1234, // arbitrary value
	parameter logic [15:0] DEVICE_TYPE  = 16'h0001, // arbitrary value
	parameter logic [7:0]  REVISION     = 8'h01,    // arbitrary value
	parameter logic [23:0] CLASS_CODE   = 24'h000000, // arbitrary value
	parameter logic [23:0] COMPANY_CODE = 24'hABCDEF, // arbitrary value
	parameter logic [23:0] PRODUCT_CODE = 24'h000001  // arbitrary value
) (
	// clock and reset
	input  wire logic                  ref_clk,
	input  wire logic                  rst,
	// pin: card/bus mode select, low selects bus mode
	input  wire logic                  cardOn,
	// configuration access
	input  wire cfg_ident_pkg::cfg_req_t cfgReq,
	output logic                       cfgAck,
	output logic [31:0]                cfgRdata,
	// physical-layer register read
	input  wire cfg_ident_pkg::phy_req_t phyReq,
	output logic                       phyAck,
	output logic [7:0]                 phyRdata,
	// requests from the rest of the controller
	input  wire logic                  memHit,
	input  wire logic                  ioHit,
	input  wire logic                  masterReq,
	input  wire logic                  mwiWanted,
	input  wire logic                  perrSeen,
	input  wire logic                  serrCause,
	// gated answers and control levels
	output logic                       memClaim,
	output logic                       ioClaim,
	output logic                       masterGo,
	output logic                       mwiUse,
	output logic                       perrAct,
	output logic                       serrAct,
	output cfg_ident_pkg::cmd_ctl_t    cmdCtl
);

	// storage
	logic [15:0] cmd_ff;
	logic [7:0]  cache_ff;
	logic [7:0]  latency_ff;
	logic        cardSyncA_ff;
	logic        cardSyncB_ff;
	logic        cardSyncC_ff;
	logic        cardMode_ff;
	logic        cfgAck_ff;
	logic [31:0] cfgRdata_ff;
	logic        phyAck_ff;
	logic [7:0]  phyRdata_ff;
	logic        memClaim_ff;
	logic        ioClaim_ff;
	logic        masterGo_ff;
	logic        mwiUse_ff;
	logic        perrAct_ff;
	logic        serrAct_ff;

	// next values
	logic [15:0] nxt_cmd;
	logic [7:0]  nxt_cache;
	logic [7:0]  nxt_latency;
	logic [31:0] nxt_cfgRdata;
	logic [7:0]  nxt_phyRdata;

	// decode of configuration accesses
	wire logic        busMode  = ~cardMode_ff;
	wire logic        cfgWr    = cfgReq.sel & cfgReq.write & busMode;
	wire logic        hitCmd   = cfgReq.idx == cfg_ident_pkg::IDX_CMDSTAT;
	wire logic        hitMisc  = cfgReq.idx == cfg_ident_pkg::IDX_MISC;
	wire logic [15:0] cmdBe    = {{8{cfgReq.be[1]}}, {8{cfgReq.be[0]}}};
	wire logic [15:0] cmdWrMsk = cmdBe & cfg_ident_pkg::CMD_WMASK;

	// command register write merge, only writable bits change
	// memory enable
	assign nxt_cmd = (cfgWr && hitCmd)
		? ((cmd_ff & ~cmdWrMsk) | (cfgReq.wdata[15:0] & cmdWrMsk))
		: cmd_ff;

	// cache line size and latency timer byte writes
	assign nxt_cache = (cfgWr && hitMisc && cfgReq.be[cfg_ident_pkg::LANE_CACHE])
		? cfgReq.wdata[7:0] : cache_ff;
	assign nxt_latency = (cfgWr && hitMisc && cfgReq.be[cfg_ident_pkg::LANE_LATENCY])
		? cfgReq.wdata[15:8] : latency_ff;

	// header read image
	// maker identifier
	wire logic [31:0] rdIdent = {DEVICE_TYPE, MAKER_ID};
	wire logic [31:0] rdCmd   = {16'h0000, cmd_ff & cfg_ident_pkg::CMD_WMASK};
	wire logic [31:0] rdClass = {CLASS_CODE, REVISION};
	wire logic [31:0] rdMisc  = {16'h0000, latency_ff, cache_ff};

	always_comb begin
		nxt_cfgRdata = 32'h00000000;
		if (busMode) begin
			unique case (cfgReq.idx)
				cfg_ident_pkg::IDX_IDENT:   nxt_cfgRdata = rdIdent;
				cfg_ident_pkg::IDX_CMDSTAT: nxt_cfgRdata = rdCmd;
				cfg_ident_pkg::IDX_CLASS:   nxt_cfgRdata = rdClass;
				cfg_ident_pkg::IDX_MISC:    nxt_cfgRdata = rdMisc;
				default:                    nxt_cfgRdata = 32'h00000000;
			endcase
		end
	end

	// physical-layer vendor page read image
	// page select
	wire logic vendorPage = phyReq.page == cfg_ident_pkg::PAGE_VENDOR;

	always_comb begin
		nxt_phyRdata = 8'h00;
		if (vendorPage) begin
			unique case (phyReq.addr)
				cfg_ident_pkg::PA_COMPLY:   nxt_phyRdata = cfg_ident_pkg::COMPLY_RESET;
				cfg_ident_pkg::PA_COMPANY0: nxt_phyRdata = COMPANY_CODE[23:16];
				cfg_ident_pkg::PA_COMPANY1: nxt_phyRdata = COMPANY_CODE[15:8];
				cfg_ident_pkg::PA_COMPANY2: nxt_phyRdata = COMPANY_CODE[7:0];
				cfg_ident_pkg::PA_PRODUCT0: nxt_phyRdata = PRODUCT_CODE[23:16];
				cfg_ident_pkg::PA_PRODUCT1: nxt_phyRdata = PRODUCT_CODE[15:8];
				cfg_ident_pkg::PA_PRODUCT2: nxt_phyRdata = PRODUCT_CODE[7:0];
				default:                    nxt_phyRdata = 8'h00;
			endcase
		end
	end

	// card select synchroniser, change taken once second and third agree
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cardSyncA_ff <= 1'b0;
			cardSyncB_ff <= 1'b0;
			cardSyncC_ff <= 1'b0;
			cardMode_ff  <= 1'b0;
		end else begin
			cardSyncA_ff <= cardOn;
			cardSyncB_ff <= cardSyncA_ff;
			cardSyncC_ff <= cardSyncB_ff;
			if (cardSyncB_ff == cardSyncC_ff) begin
				cardMode_ff <= cardSyncC_ff;
			end
		end
	end

	// configuration registers
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cmd_ff     <= cfg_ident_pkg::CMD_RESET;
			cache_ff   <= cfg_ident_pkg::CACHE_RESET;
			latency_ff <= cfg_ident_pkg::LATENCY_RESET;
		end else begin
			cmd_ff     <= nxt_cmd;
			cache_ff   <= nxt_cache;
			latency_ff <= nxt_latency;
		end
	end

	// config port answer, one cycle after each access, data only on reads
	// header answer
	answer_reg #(
		.WIDTH(32)
	) i_cfgAnswer (
		.ref_clk (ref_clk),
		.rst     (rst),
		.strobe  (cfgReq.sel),
		.isRead  (~cfgReq.write),
		.image   (nxt_cfgRdata),
		.ack     (cfgAck_ff),
		.rdata   (cfgRdata_ff)
	);

	// physical-layer port answer, every request there is a read
	// unused read zero
	answer_reg #(
		.WIDTH(8)
	) i_phyAnswer (
		.ref_clk (ref_clk),
		.rst     (rst),
		.strobe  (phyReq.rd),
		.isRead  (1'b1),
		.image   (nxt_phyRdata),
		.ack     (phyAck_ff),
		.rdata   (phyRdata_ff)
	);

	// invalidate needs a master request and both master and invalidate enables
	wire logic mwiReq   = masterReq & mwiWanted;
	wire logic mwiAllow = cmd_ff[cfg_ident_pkg::CMD_MASTER] & cmd_ff[cfg_ident_pkg::CMD_MWI];

	// gating of bus activity by the command bits, one cycle of latency each
	// memory claim
	cmd_gate_flop i_memGate (
		.ref_clk (ref_clk),
		.rst     (rst),
		.req     (memHit),
		.enable  (cmd_ff[cfg_ident_pkg::CMD_MEM]),
		.gated   (memClaim_ff)
	);

	cmd_gate_flop i_ioGate (
		.ref_clk (ref_clk),
		.rst     (rst),
		.req     (ioHit),
		.enable  (cmd_ff[cfg_ident_pkg::CMD_IO]), // constant low bit, so never set
		.gated   (ioClaim_ff)
	);

	cmd_gate_flop i_masterGate (
		.ref_clk (ref_clk),
		.rst     (rst),
		.req     (masterReq),
		.enable  (cmd_ff[cfg_ident_pkg::CMD_MASTER]),
		.gated   (masterGo_ff)
	);

	cmd_gate_flop i_mwiGate (
		.ref_clk (ref_clk),
		.rst     (rst),
		.req     (mwiReq),
		.enable  (mwiAllow),
		.gated   (mwiUse_ff)
	);

	cmd_gate_flop i_perrGate (
		.ref_clk (ref_clk),
		.rst     (rst),
		.req     (perrSeen),
		.enable  (cmd_ff[cfg_ident_pkg::CMD_PERR]),
		.gated   (perrAct_ff)
	);

	cmd_gate_flop i_serrGate (
		.ref_clk (ref_clk),
		.rst     (rst),
		.req     (serrCause),
		.enable  (cmd_ff[cfg_ident_pkg::CMD_SERR]),
		.gated   (serrAct_ff)
	);

	// outputs straight from flip-flops
	assign cfgAck   = cfgAck_ff;
	assign cfgRdata = cfgRdata_ff;
	assign phyAck   = phyAck_ff;
	assign phyRdata = phyRdata_ff;
	assign memClaim = memClaim_ff;
	assign ioClaim  = ioClaim_ff;
	assign masterGo = masterGo_ff;
	assign mwiUse   = mwiUse_ff;
	assign perrAct  = perrAct_ff;
	assign serrAct  = serrAct_ff;
	// command enables as levels, one driver for the whole struct
	assign cmdCtl = '{
		memEn:    cmd_ff[cfg_ident_pkg::CMD_MEM],
		masterEn: cmd_ff[cfg_ident_pkg::CMD_MASTER],
		mwiEn:    cmd_ff[cfg_ident_pkg::CMD_MWI],
		perrEn:   cmd_ff[cfg_ident_pkg::CMD_PERR],
		serrEn:   cmd_ff[cfg_ident_pkg::CMD_SERR]
	};

endmodule : pci_config_ident_command

// request level registered and gated by one command enable bit
module cmd_gate_flop (
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic rst,
	// request and its enabling command bit
	input  wire logic req,
	input  wire logic enable,
	// gated level, one cycle late
	output logic      gated
);

	logic gated_ff;

	// reset clears the level so nothing leaks out during reset
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			gated_ff <= 1'b0;
		end else begin
			gated_ff <= req & enable;
		end
	end

	assign gated = gated_ff;

endmodule : cmd_gate_flop

// one-cycle answer register shared by both access ports
module answer_reg #(
	parameter int WIDTH = 8
) (
	// clock and reset
	input  wire logic             ref_clk,
	input  wire logic             rst,
	// request strobe, read qualifier and read image
	input  wire logic             strobe,
	input  wire logic             isRead,
	input  wire logic [WIDTH-1:0] image,
	// answer, standing for one cycle
	output logic                  ack,
	output logic [WIDTH-1:0]      rdata
);

	logic             ack_ff;
	logic [WIDTH-1:0] rdata_ff;

	// data is zero unless a read is answered, so stale values never show
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ack_ff   <= 1'b0;
			rdata_ff <= '0;
		end else begin
			ack_ff   <= strobe;
			rdata_ff <= (strobe && isRead) ? image : '0;
		end
	end

	assign ack   = ack_ff;
	assign rdata = rdata_ff;

endmodule : answer_reg
`default_nettype wire

// [sim/cfg_host_model.sv]
`default_nettype none
module cfg_host_model (
	// clock and request
	input wire logic                     ref_clk,
	output var cfg_ident_pkg::cfg_req_t  cfgReq
);
	timeunit 1ns;
	timeprecision 1ns;
	// one access per call, raised for a single sampling edge
	task automatic access(input logic w, input logic [5:0] i, input logic [3:0] b,
		input logic [31:0] d);
		cfgReq = '{1'b1, w, i, b, d};
		@(negedge ref_clk);
	endtask : access
	// released fields turn over so stale data never looks valid
	task automatic idle(input int n);
		cfgReq = '{1'b0, ~cfgReq.write, ~cfgReq.idx, ~cfgReq.be, ~cfgReq.wdata};
		repeat (n + 1) @(negedge ref_clk);
	endtask : idle
	initial cfgReq = '0;
endmodule : cfg_host_model
`default_nettype wire

// [sim/cfg_ident_sva.sv]
`default_nettype none
module cfg_ident_sva (
	// clock and reset
	input wire logic                     ref_clk,
	input wire logic                     rst,
	// register ports
	input wire cfg_ident_pkg::cfg_req_t  cfgReq,
	input wire logic                     cfgAck,
	input wire logic [31:0]              cfgRdata,
	input wire cfg_ident_pkg::phy_req_t  phyReq,
	input wire logic                     phyAck,
	input wire logic [7:0]               phyRdata,
	// gating
	input wire logic                     memHit,
	input wire logic                     perrSeen,
	input wire logic                     masterReq,
	input wire logic                     mwiWanted,
	input wire logic                     serrCause,
	input wire logic                     memClaim,
	input wire logic                     ioClaim,
	input wire logic                     masterGo,
	input wire logic                     perrAct,
	input wire logic                     mwiUse,
	input wire logic                     serrAct,
	input wire cfg_ident_pkg::cmd_ctl_t  cmdCtl
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	ack_follow_a: assert property (cfgReq.sel |=> cfgAck)
		else $error("config access not acknowledged");
	ack_spur_a: assert property (!cfgReq.sel |=> !cfgAck)
		else $error("acknowledge without access");
	io_never_a: assert property (!ioClaim)
		else $error("io access claimed");
	mem_gate_a: assert property (memHit && cmdCtl.memEn |=> memClaim)
		else $error("memory cycle not claimed");
	mem_off_a: assert property (!cmdCtl.memEn |=> !memClaim)
		else $error("memory claimed while disabled");
	master_off_a: assert property (!cmdCtl.masterEn |=> !masterGo)
		else $error("mastering while disabled");
	perr_gate_a: assert property (perrAct |-> $past(perrSeen) && $past(cmdCtl.perrEn))
		else $error("parity reaction without cause");
	cmd_const_a: assert property (cfgReq.sel && !cfgReq.write && cfgReq.idx == 6'h01 |=>
		(cfgRdata[15:0] & ~cfg_ident_pkg::CMD_WMASK) == 16'h0000)
		else $error("constant command bit set");
	comply_rd_a: assert property (phyReq.rd && phyReq.page == 3'h1 && phyReq.addr == 4'h8
		|=> phyAck && phyRdata == 8'h01)
		else $error("compliance level wrong");
	port_page_a: assert property (phyReq.rd && phyReq.page == 3'h0 |=> phyRdata == 8'h00)
		else $error("port page not zero");
	master_on_a: assert property (masterReq && cmdCtl.masterEn |=> masterGo)
		else $error("master request not passed");
	mwi_gate_a: assert property (mwiUse == ($past(masterReq) && $past(mwiWanted)
		&& $past(cmdCtl.masterEn) && $past(cmdCtl.mwiEn)))
		else $error("invalidate use wrong");
	serr_gate_a: assert property (serrAct == ($past(serrCause) && $past(cmdCtl.serrEn)))
		else $error("system error reaction wrong");
endmodule : cfg_ident_sva
bind pci_config_ident_command cfg_ident_sva i_sva (.*);
`default_nettype wire

// [sim/test_pci_config_ident_command.sv]
`default_nettype none
module test_pci_config_ident_command;
	timeunit 1ns;
	timeprecision 1ns;
	// identity values, all arbitrary
	localparam logic [15:0] MKR = 16'h5A5A;
	localparam logic [15:0] DEV = 16'h0A0B;
	localparam logic [7:0]  REV = 8'h3C;
	localparam logic [23:0] CLS = 24'h123456;
	localparam logic [23:0] CMP = 24'h13579B;
	localparam logic [23:0] PRD = 24'h2468AC;
	logic                     ref_clk = 1'b0;
	logic                     rst = 1'b1;
	logic                     cardOn = 1'b0;
	logic [5:0]               hit = 6'h00;
	cfg_ident_pkg::cfg_req_t  cfgReq;
	cfg_ident_pkg::phy_req_t  phyReq = '0;
	cfg_ident_pkg::cmd_ctl_t  cmdCtl;
	logic                     cfgAck;
	logic                     phyAck;
	logic [31:0]              cfgRdata;
	logic [7:0]               phyRdata;
	logic [31:0]              cq[$];
	logic [7:0]               pq[$];
	logic [15:0]              cmd;
	logic [15:0]              msc;
	int                       mismatches = 0;
	int                       num_checks = 0;
	cfg_host_model i_host (.ref_clk(ref_clk), .cfgReq(cfgReq));
	pci_config_ident_command #(.MAKER_ID(MKR), .DEVICE_TYPE(DEV), .REVISION(REV),
		.CLASS_CODE(CLS), .COMPANY_CODE(CMP), .PRODUCT_CODE(PRD)) i_dut (
		.ref_clk(ref_clk), .rst(rst), .cardOn(cardOn), .cfgReq(cfgReq), .cfgAck(cfgAck),
		.cfgRdata(cfgRdata), .phyReq(phyReq), .phyAck(phyAck), .phyRdata(phyRdata),
		.memHit(hit[0]), .ioHit(hit[1]), .masterReq(hit[2]), .mwiWanted(hit[3]),
		.perrSeen(hit[4]), .serrCause(hit[5]), .memClaim(), .ioClaim(), .masterGo(),
		.mwiUse(), .perrAct(), .serrAct(), .cmdCtl(cmdCtl));
	initial forever #25 ref_clk = ~ref_clk;
	// compare one result and count it
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	task automatic close_out;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : close_out
	// expected header contents from the shadow copy
	function automatic logic [31:0] rdv(input logic [5:0] i);
		case (i)
			6'h00: return {DEV, MKR};
			6'h01: return {16'h0000, cmd};
			6'h02: return {CLS, REV};
			6'h03: return {16'h0000, msc};
			default: return 32'h00000000;
		endcase
	endfunction : rdv
	// one config access: update shadow, note result, send
	task automatic cfg(input logic w, input logic [5:0] i, input logic [3:0] b,
		input logic [31:0] d);
		logic [15:0] m;
		m = {{8{b[1]}}, {8{b[0]}}};
		if (w && !cardOn && i == 6'h01) cmd = (cmd & ~(m & 16'h0156)) | (d[15:0] & m & 16'h0156);
		if (w && !cardOn && i == 6'h03) msc = (msc & ~m) | (d[15:0] & m);
		cq.push_back((w || cardOn) ? 32'h00000000 : rdv(i));
		hit = 6'($urandom);
		i_host.access(w, i, b, d);
	endtask : cfg
	task automatic phy(input logic [2:0] p, input logic [3:0] a);
		logic [7:0] e;
		e = 8'h00;
		if (p == 3'h1 && a == 4'h8) e = 8'h01;
		if (p == 3'h1 && a inside {[4'h9:4'hB]}) e = 8'(CMP >> (8 * (11 - a)));
		if (p == 3'h1 && a inside {[4'hC:4'hE]}) e = 8'(PRD >> (8 * (14 - a)));
		pq.push_back(e);
		phyReq = '{1'b1, p, a};
		@(negedge ref_clk);
	endtask : phy
	// each acknowledge takes the oldest note
	always @(negedge ref_clk) begin
		if (cfgAck === 1'b1) chk("cfgRdata", cq.size() ? cq.pop_front() : 'x, cfgRdata);
		if (phyAck === 1'b1) chk("phyRdata", pq.size() ? pq.pop_front() : 'x, phyRdata);
	end
	initial begin
		#250000;
		mismatches++;
		close_out();
	end
	initial begin
		int k;
		logic [31:0] r;
		r = $urandom(32'h389C9794);
		cmd = cfg_ident_pkg::CMD_RESET;
		msc = 16'h0000;
		repeat (10) @(negedge ref_clk);
		rst = 1'b0;
		for (k = 0; k < 5; k++) cfg(1'b0, 6'(k), 4'hF, 32'h0);
		chk("cmdCtl", 32'({cmd[1], cmd[2], cmd[4], cmd[6], cmd[8]}), 32'(cmdCtl));
		$display("test reset_values done");
		for (k = 0; k < 4; k++) begin
			cfg(1'b1, 6'(k), 4'hF, 32'hFFFFFFFF);
			cfg(1'b0, 6'(k), 4'hF, 32'h0);
		end
		chk("cmdCtl", 32'({cmd[1], cmd[2], cmd[4], cmd[6], cmd[8]}), 32'(cmdCtl));
		$display("test write_ones done");
		for (k = 0; k < 60; k++) begin
			r = $urandom;
			cfg(1'b1, 6'(r[2:0]), r[7:4], $urandom);
			cfg(1'b0, 6'(r[2:0]), 4'hF, 32'h0);
			if (r[8]) i_host.idle(int'(r[10:9]));
		end
		i_host.idle(0);
		chk("cmdCtl", 32'({cmd[1], cmd[2], cmd[4], cmd[6], cmd[8]}), 32'(cmdCtl));
		$display("test random_access done");
		for (k = 0; k < 48; k++) phy(3'(k / 16), 4'(k));
		phyReq.rd = 1'b0;
		$display("test phy_pages done");
		cardOn = 1'b1;
		i_host.idle(8);
		for (k = 0; k < 4; k++) cfg(1'b0, 6'(k), 4'hF, 32'h0);
		cfg(1'b1, 6'h01, 4'hF, ~{16'h0000, cmd});
		i_host.idle(0);
		cardOn = 1'b0;
		i_host.idle(8);
		cfg(1'b0, 6'h01, 4'hF, 32'h0);
		i_host.idle(0);
		$display("test card_mode done");
		for (k = 0; k < 10 && cq.size() + pq.size() > 0; k++) @(negedge ref_clk);
		if (cq.size() + pq.size() > 0) mismatches++;
		close_out();
	end
endmodule : test_pci_config_ident_command
`default_nettype wire
